// ---- design/ident_bank.sv ----
// Identification and scratchpad command bank of a power system manager.
// Assumes a PMBus engine on sys_clk issuing one request at a time and an
// nonvolatile restore engine that writes stored words after reset.
//
// Behaviour
// - Capability bit 7 always set
// - Capability bits 6:5 read 01
// - Capability bit 4 always set
// - Capability read returns constant B0
// - Revision read returns 11
// - Maker identification word is fixed
// - Paged read-only lot byte, restored
// - User and reserved words read and write
// - Scratch words: unpaged plus four, zero
// - Separate flag shows mandatory error checking
`timescale 1ns/100ps
module ident_bank
	import ident_pkg::*;
#(
	parameter logic [15:0] MAKER_ID = 16'h5A5A, // Arbitrary value
	parameter int          PAGES    = 4
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                nrst,
	// Command port
	input  wire ident_pkg::cmd_req_s req,
	output logic                     req_ready,
	output ident_pkg::cmd_rsp_s      rsp,
	// Restore from nonvolatile store
	input  wire ident_pkg::nvm_load_s nvm,
	output logic                     nvm_ready,
	// Configuration
	input  wire logic                pec_en_cfg,
	output logic                     pec_required
);
	import ident_pkg::*;

	typedef enum logic [1:0] {
		ST_INIT = 2'b01,
		ST_IDLE = 2'b10
	} bank_state_e;

	bank_state_e          state_ff;
	bank_state_e          nxt_state;
	logic [STORE_AW-1:0]  init_cnt_ff;
	logic [STORE_AW-1:0]  nxt_init_cnt;
	logic                 rsp_valid_ff;
	logic                 rsp_err_ff;
	logic                 sel_mem_ff;
	logic [15:0]          fixed_ff;
	logic                 pec_ff;
	logic [15:0]          mem_rdata;

	// Page count is built into the store layout
	if (PAGES != PAGE_COUNT)
		$error("ident_bank: PAGES must equal the store page count");

	// Command decode
	wire hit_cap   = (req.code == CMD_CAPABILITY);
	wire hit_rev   = (req.code == CMD_REVISION);
	wire hit_id    = (req.code == CMD_MAKER_ID);
	wire hit_lot   = (req.code == CMD_LOT);
	wire hit_tla   = (req.code == CMD_TOOL_A);
	wire hit_tlp   = (req.code == CMD_TOOL_PAGED);
	wire hit_oem   = (req.code == CMD_OEM);
	wire hit_scp   = (req.code == CMD_SCRATCH_PG);
	wire hit_scu   = (req.code == CMD_SCRATCH_UNPG);
	wire hit_mk1   = (req.code == CMD_MAKER_ONE);
	wire hit_mk2   = (req.code == CMD_MAKER_TWO);
	wire hit_rw    = hit_tla | hit_tlp | hit_oem | hit_scp | hit_scu
	               | hit_mk1 | hit_mk2;
	wire hit_ro    = hit_cap | hit_rev | hit_id | hit_lot;
	wire hit_mem   = hit_rw | hit_lot;
	wire is_paged  = hit_tlp | hit_scp | hit_mk1 | hit_mk2 | hit_lot;

	// Slot select; unpaged words always sit at page zero
	wire [SLOT_W-1:0] slot =
		hit_tlp ? SLOT_TOOL_PG  :
		hit_oem ? SLOT_OEM      :
		hit_scp ? SLOT_SCR_PG   :
		hit_scu ? SLOT_SCR_UNPG :
		hit_mk1 ? SLOT_MAKER1   :
		hit_mk2 ? SLOT_MAKER2   :
		hit_lot ? SLOT_LOT      : SLOT_TOOL_A;
	wire [PAGE_W-1:0]   page_sel = is_paged ? req.page : '0;
	wire [STORE_AW-1:0] req_addr = {slot, page_sel};

	// Handshake: nothing is taken during the sweep or a restore write
	wire in_idle   = (state_ff == ST_IDLE);
	assign nvm_ready = in_idle;
	assign req_ready = in_idle & ~nvm.we;
	wire taken     = req_ready & (req.rd | req.wr);
	wire rd_taken  = taken & req.rd & ~req.wr;
	// A request with both strobes set is refused, so it must not write
	wire host_we   = taken & req.wr & ~req.rd & hit_rw;
	wire bad_req   = ~(hit_mem | hit_ro) | (req.wr & hit_ro) | (req.rd
	                 & req.wr);

	// Store write mux: sweep, then restore, then host
	wire init_we   = ~in_idle;
	wire nvm_we    = in_idle & nvm.we;
	// Lot entries keep only their byte; the upper half always reads zero
	wire lot_load  = (nvm.addr[STORE_AW-1:PAGE_W] == SLOT_LOT);
	wire [15:0] nvm_word = lot_load ? {8'h00, nvm.wdata[7:0]} : nvm.wdata;
	wire st_we     = init_we | nvm_we | host_we;
	wire [STORE_AW-1:0] st_waddr = init_we ? init_cnt_ff :
		nvm_we ? nvm.addr : req_addr;
	wire [15:0] st_wdata = init_we ? WORD_RESET :
		nvm_we ? nvm_word : req.wdata;

	// Fixed read values
	wire [7:0] cap_byte = CAPABILITY_VAL;
	wire [15:0] fixed_sel =
		hit_cap ? {8'h00, cap_byte}      :
		hit_rev ? {8'h00, REVISION_VAL}  :
		hit_id  ? MAKER_ID               : 16'h0000;

	word_store #(
		.WIDTH (16),
		.DEPTH (STORE_DEPTH)
	) u_store (
		.sys_clk (sys_clk),
		.we      (st_we),
		.waddr   (st_waddr),
		.wdata   (st_wdata),
		.raddr   (req_addr),
		.rdata   (mem_rdata)
	);

	// Sweep sequence clears every word after reset
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_init_cnt = init_cnt_ff;
		case (state_ff)
			ST_INIT:
			begin
				nxt_init_cnt = init_cnt_ff + 1'b1;
				if (&init_cnt_ff)
					nxt_state = ST_IDLE;
			end
			ST_IDLE: nxt_state = ST_IDLE;
			default: nxt_state = ST_INIT;
		endcase
	end

	// State registers
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff    <= ST_INIT;
			init_cnt_ff <= '0;
		end
		else
		begin
			state_ff    <= nxt_state;
			init_cnt_ff <= nxt_init_cnt;
		end
	end

	// Answer registers, one edge after the request is taken
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_err_ff   <= 1'b0;
			sel_mem_ff   <= 1'b0;
			fixed_ff     <= 16'h0000;
			pec_ff       <= 1'b0;
		end
		else
		begin
			rsp_valid_ff <= taken;
			rsp_err_ff   <= taken & bad_req;
			sel_mem_ff   <= rd_taken & hit_mem;
			fixed_ff     <= rd_taken ? fixed_sel : 16'h0000;
			pec_ff       <= pec_en_cfg;
		end
	end

	// Both sources are flip-flops; unselected data read as zero
	wire [15:0] rsp_rdata = sel_mem_ff ? mem_rdata : fixed_ff;
	assign rsp = '{valid: rsp_valid_ff, err: rsp_err_ff, rdata: rsp_rdata};
	assign pec_required = pec_ff;

	// Assertion helper: counts sweep edges independently of the sweep counter
	logic [STORE_AW:0] sweep_len_ff;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			sweep_len_ff <= '0;
		else
			sweep_len_ff <= sweep_len_ff + {{STORE_AW{1'b0}}, init_we};
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	AST_CAP_PEC: assert property (
		rd_taken && hit_cap |=> rsp.valid && rsp.rdata[CAP_PEC_BIT])
		else $error("capability error checking bit not set");

	AST_CAP_SPEED: assert property (
		rd_taken && hit_cap |=>
		rsp.rdata[CAP_SPEED_LSB+1:CAP_SPEED_LSB] == CAP_SPEED_400K)
		else $error("capability speed field wrong");

	AST_CAP_ALERT: assert property (
		rd_taken && hit_cap |=> rsp.rdata[CAP_ALERT_BIT])
		else $error("capability alert bit not set");

	AST_CAP_VALUE: assert property (
		rd_taken && hit_cap |=> !rsp.err && rsp.rdata == 16'h00B0)
		else $error("capability byte not B0");

	AST_REV_VALUE: assert property (
		rd_taken && hit_rev |=> rsp.valid && rsp.rdata == 16'h0011)
		else $error("revision byte not 11");

	AST_ID_VALUE: assert property (
		rd_taken && hit_id |=> rsp.rdata == MAKER_ID)
		else $error("maker identification changed");

	AST_LOT_RESTORE: assert property (
		nvm_we && nvm.addr[4:2] == SLOT_LOT ##1
		(rd_taken && hit_lot && req_addr == $past(nvm.addr))
		|=> rsp.rdata == {8'h00, $past(nvm.wdata[7:0], 2)})
		else $error("lot byte does not show restored value");

	AST_WORD_RW: assert property (
		host_we ##1 (rd_taken && hit_rw && req_addr == $past(req_addr))
		|=> rsp.rdata == $past(req.wdata, 2))
		else $error("stored word not read back");

	AST_SWEEP_LEN: assert property (
		$fell(init_we) |-> $past(init_we, 32) && init_cnt_ff == '0
		&& sweep_len_ff == STORE_DEPTH)
		else $error("clear sweep length wrong");

	AST_PEC_FLAG: assert property (
		##1 pec_required == $past(pec_en_cfg))
		else $error("error checking flag does not follow config");

	AST_RO_WRITE: assert property (
		taken && req.wr && hit_ro |-> !st_we ##1 rsp.valid && rsp.err)
		else $error("write to read-only value accepted");

endmodule // ident_bank

// ---- design/ident_pkg.sv ----
// Constants and carriers for the identification and scratchpad bank.
// Assumes a PMBus protocol engine on the same clock that decodes commands
// and pages and hands single read or write requests to the bank.
package ident_pkg;

	// Command codes
	localparam logic [7:0] CMD_CAPABILITY   = 8'h19;
	localparam logic [7:0] CMD_REVISION     = 8'h98;
	localparam logic [7:0] CMD_TOOL_A       = 8'hB0;
	localparam logic [7:0] CMD_TOOL_PAGED   = 8'hB1;
	localparam logic [7:0] CMD_OEM          = 8'hB2;
	localparam logic [7:0] CMD_SCRATCH_PG   = 8'hB3;
	localparam logic [7:0] CMD_SCRATCH_UNPG = 8'hB4;
	localparam logic [7:0] CMD_MAKER_ONE    = 8'hB5;
	localparam logic [7:0] CMD_MAKER_TWO    = 8'hBC;
	localparam logic [7:0] CMD_MAKER_ID     = 8'hE7;
	localparam logic [7:0] CMD_LOT          = 8'hE8;

	// Capability byte fields
	localparam int          CAP_PEC_BIT   = 7;
	localparam int          CAP_SPEED_LSB = 5;
	localparam logic [1:0]  CAP_SPEED_400K = 2'h1;
	localparam int          CAP_ALERT_BIT = 4;
	localparam logic [7:0]  CAPABILITY_VAL = 8'hB0;
	localparam logic [7:0]  REVISION_VAL   = 8'h11;

	// Word store layout: index is {slot, page}
	localparam int         PAGE_COUNT = 4;
	localparam int         PAGE_W     = 2;
	localparam int         SLOT_W     = 3;
	localparam int         STORE_AW   = SLOT_W + PAGE_W;
	localparam int         STORE_DEPTH = 32;
	localparam logic [2:0] SLOT_TOOL_A   = 3'h0;
	localparam logic [2:0] SLOT_TOOL_PG  = 3'h1;
	localparam logic [2:0] SLOT_OEM      = 3'h2;
	localparam logic [2:0] SLOT_SCR_PG   = 3'h3;
	localparam logic [2:0] SLOT_SCR_UNPG = 3'h4;
	localparam logic [2:0] SLOT_MAKER1   = 3'h5;
	localparam logic [2:0] SLOT_MAKER2   = 3'h6;
	localparam logic [2:0] SLOT_LOT      = 3'h7;
	localparam logic [15:0] WORD_RESET   = 16'h0000;

	// Request from the protocol engine
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  code;
		logic [1:0]  page;
		logic [15:0] wdata;
	} cmd_req_s;

	// Answer to the protocol engine
	typedef struct packed {
		logic        valid;
		logic        err;
		logic [15:0] rdata;
	} cmd_rsp_s;

	// Restore path from the nonvolatile store
	typedef struct packed {
		logic        we;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} nvm_load_s;

endpackage

// ---- design/word_store.sv ----
// Small single-port-write, registered-read word memory.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/100ps
module word_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock
	input  wire logic                     sys_clk,
	// Write port
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [WIDTH-1:0]         wdata,
	// Read port
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [WIDTH-1:0]         rdata
);

	logic [WIDTH-1:0] mem_ff [DEPTH];

	// Power-of-two depth keeps every address a real entry
	if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0))
		$error("word_store: DEPTH must be a power of two");

	// No reset on the array; the owner sweeps it after reset
	always_ff @(posedge sys_clk)
	begin
		if (we)
			mem_ff[waddr] <= wdata;
		rdata <= mem_ff[raddr]; // Read before write on a clash
	end

endmodule // word_store

// ---- bench/pmbus_host_model.sv ----
// Host-side model of the PMBus engine that feeds the bank one request.
// Assumes the bench calls xfer; request fields move on falling edges.
`timescale 1ns/100ps
module pmbus_host_model
	import ident_pkg::*;
(
	// Clock
	input  wire logic                sys_clk,
	// Command port
	output ident_pkg::cmd_req_s      req,
	input  wire logic                req_ready,
	input  wire ident_pkg::cmd_rsp_s rsp
);
	initial req = '0;

	// Hold the request until an edge takes it, then grab the answer.
	// at_once: caller stands on a falling edge and the port is free there.
	// keep: leave the request up so a back-to-back call replaces it.
	task automatic xfer(input cmd_req_s c, input bit at_once, keep,
		output cmd_rsp_s r, output bit ok);
		int n;
		ok = 0;
		if (!at_once)
			@(negedge sys_clk);
		req = c;
		for (n = 0; n < 50 && !ok; n++)
		begin
			ok = (req_ready === 1'b1);
			@(posedge sys_clk);
			if (!ok)
				@(negedge sys_clk);
		end
		@(negedge sys_clk);
		r = rsp;
		// Strobes drop, code and data toggle so stale values are never mistaken as live
		if (!keep)
			req = '{1'b0, 1'b0, ~c.code, c.page, ~c.wdata};
	endtask
endmodule // pmbus_host_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the identification and scratchpad bank.
// Assumes the host model drives the command port; bench drives restore.
`timescale 1ns/100ps
module tb_top;
	import ident_pkg::*;
	localparam logic [15:0] ID_VAL = 16'h3C96; // Arbitrary value
	logic        sys_clk, nrst, pec_en_cfg;
	logic        req_ready, nvm_ready, pec_required;
	cmd_req_s    req;
	cmd_rsp_s    rsp;
	nvm_load_s   nvm;
	logic [15:0] mem [32];
	logic [7:0]  rw_code [7] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5,
		8'hBC};
	logic [7:0]  ro_code [4] = '{8'h19, 8'h98, 8'hE7, 8'hE8};
	logic [7:0]  c;
	logic [1:0]  p;
	logic [15:0] d;
	int          fail_count = 0, n_compared = 0, seed = 91, i;

	ident_bank #(.MAKER_ID(ID_VAL), .PAGES(4)) ident_bank_i (
		.sys_clk(sys_clk), .nrst(nrst), .req(req), .req_ready(req_ready),
		.rsp(rsp), .nvm(nvm), .nvm_ready(nvm_ready),
		.pec_en_cfg(pec_en_cfg), .pec_required(pec_required));
	pmbus_host_model pmbus_host_model_i (.sys_clk(sys_clk), .req(req),
		.req_ready(req_ready), .rsp(rsp));

	initial
	begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Store index: unpaged words always sit at page 0
	function automatic logic [4:0] idx(logic [7:0] cd, logic [1:0] pg);
		logic [2:0] s;
		s = (cd == 8'hBC) ? 3'h6 : (cd == 8'hE8) ? 3'h7 : cd[2:0];
		return {s, (cd inside {8'hB1, 8'hB3, 8'hB5, 8'hBC, 8'hE8}) ? pg : 2'h0};
	endfunction

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One transfer, then compare the whole answer
	task automatic op(logic rd, wr, logic [7:0] cd, logic [1:0] pg,
		logic [15:0] wd, logic [15:0] er, logic ee, bit at_once = 0,
		bit keep = 0);
		cmd_rsp_s r;
		bit ok;
		pmbus_host_model_i.xfer('{rd, wr, cd, pg, wd}, at_once, keep, r, ok);
		if (!ok)
		begin
			fail_count++;
			stop_test();
		end
		chk("rsp_valid", 16'h1, {15'h0, r.valid});
		chk("rsp_err", {15'h0, ee}, {15'h0, r.err});
		chk("rsp_rdata", er, r.rdata);
	endtask

	initial
	begin
		nrst = 0;
		pec_en_cfg = 0;
		nvm = '0;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1;
		chk("nvm_ready", 16'h0000, {15'h0, nvm_ready});
		for (i = 0; i < 40 && req_ready !== 1'b1; i++)
			@(negedge sys_clk);
		if (req_ready !== 1'b1)
		begin
			fail_count++;
			stop_test();
		end
		chk("sweep_cycles", 16'h0020, i[15:0]);
		chk("nvm_ready", 16'h0001, {15'h0, nvm_ready});
		for (i = 0; i < 32; i++)
			mem[i] = 16'h0000;
		op(1, 0, CMD_CAPABILITY, 2'h3, 0, 16'h00B0, 0);
		op(1, 0, CMD_REVISION, 2'h1, 0, 16'h0011, 0);
		op(1, 0, CMD_MAKER_ID, 2'h2, 0, ID_VAL, 0);
		for (i = 0; i < 4; i++)
			op(1, 0, CMD_SCRATCH_PG, i[1:0], 0, 16'h0000, 0);
		op(1, 0, CMD_SCRATCH_UNPG, 2'h2, 0, 16'h0000, 0);
		$display("Test identification and clear values done");
		// Write then read on a random page, so unpaged aliasing shows up
		for (i = 0; i < 60; i++)
		begin
			c = rw_code[$unsigned($random(seed)) % 7];
			p = 2'($random(seed));
			d = 16'($random(seed));
			// Read follows the write on the very next cycle
			op(0, 1, c, p, d, 16'h0000, 0, 0, 1);
			mem[idx(c, p)] = d;
			p = 2'($random(seed));
			op(1, 0, c, p, 0, mem[idx(c, p)], 0, 1);
		end
		$display("Test random word traffic done");
		// Lot bytes arrive only from the restore path
		for (i = 0; i < 4; i++)
		begin
			d = 16'($random(seed));
			@(negedge sys_clk);
			nvm = '{1'b1, idx(CMD_LOT, i[1:0]), d};
			#1 chk("req_ready", 16'h0, {15'h0, req_ready});
			@(negedge sys_clk);
			nvm = '{1'b0, ~nvm.addr, ~d};
			mem[idx(CMD_LOT, i[1:0])] = {8'h00, d[7:0]};
			op(1, 0, CMD_LOT, i[1:0], 0, mem[idx(CMD_LOT, i[1:0])], 0, 1);
		end
		$display("Test lot restore done");
		for (i = 0; i < 4; i++)
			op(0, 1, ro_code[i], 2'h1, 16'hFFFF, 16'h0000, 1);
		op(1, 0, CMD_CAPABILITY, 2'h0, 0, 16'h00B0, 0);
		op(1, 0, CMD_REVISION, 2'h0, 0, 16'h0011, 0);
		op(1, 0, CMD_MAKER_ID, 2'h0, 0, ID_VAL, 0);
		op(1, 0, CMD_LOT, 2'h1, 0, mem[idx(CMD_LOT, 2'h1)], 0);
		op(1, 1, CMD_SCRATCH_UNPG, 2'h0, 16'h1234, 16'h0000, 1);
		op(1, 0, CMD_SCRATCH_UNPG, 2'h0, 0, mem[idx(8'hB4, 2'h0)], 0);
		op(1, 0, 8'h20, 2'h0, 0, 16'h0000, 1);
		$display("Test read-only and refused requests done");
		// Mandatory checking flag follows its input, capability stays put
		for (i = 0; i < 8; i++)
		begin
			@(negedge sys_clk);
			pec_en_cfg = (i == 7) ? 1'b1 : 1'($random(seed));
			@(negedge sys_clk);
			chk("pec_required", {15'h0, pec_en_cfg}, {15'h0, pec_required});
		end
		op(1, 0, CMD_CAPABILITY, 2'h0, 0, 16'h00B0, 0);
		$display("Test configuration flag done");
		stop_test();
	end
endmodule // tb_top
